// ---- design/tpm_pkg.sv ----
// Shared constants for the timer PWM output mode block.
// Assumes a byte-addressed register port with 32-bit data words.
package tpm_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int TPM_CHANNELS  = 16;
    localparam int TPM_CNT_WIDTH = 16;
    localparam int TPM_MAX_PWM   = 4;
    localparam int TPM_ADDR_W    = 8;
    localparam int TPM_DATA_W    = 32;
    localparam int TPM_FIELD_W   = 2;
    localparam int TPM_SEL_W     = 4;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] TPM_OFS_TIMER_CTRL = 8'h00;
    localparam logic [7:0] TPM_OFS_TIMER_CNT  = 8'h04;
    localparam logic [7:0] TPM_OFS_CYCLE_SEL  = 8'h08;
    localparam logic [7:0] TPM_OFS_PWM_SEL    = 8'h0c;
    localparam logic [7:0] TPM_OFS_EXT_MATCH  = 8'h10;
    localparam logic [7:0] TPM_OFS_MATCH_BASE = 8'h40;
    localparam logic [7:0] TPM_OFS_MODE_CTRL  = 8'h94;
    localparam logic [7:0] TPM_OFS_WORD_STEP  = 8'h04;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int TPM_BIT_RUN       = 0;
    localparam int TPM_BIT_CNT_CLEAR = 1;

    // ==========================================================
    // Reset values and count step
    // ==========================================================
    localparam logic [31:0] TPM_RST_MODE_CTRL = 32'h0000_0000;
    localparam logic [15:0] TPM_RST_MATCH     = 16'h0000;
    localparam logic [15:0] TPM_RST_COUNT     = 16'h0000;
    localparam logic [15:0] TPM_RST_MASK      = 16'h0000;
    localparam logic [3:0]  TPM_RST_CYCLE_SEL = 4'h0;
    localparam logic [31:0] TPM_READ_ZERO     = 32'h0000_0000;
    localparam logic [15:0] TPM_COUNT_STEP    = 16'h0001;

    // ==========================================================
    // Output modes of one two-bit field
    // ==========================================================
    typedef enum logic [1:0] {
        TPM_MODE_LOW_FIRST  = 2'h0,
        TPM_MODE_HIGH_FIRST = 2'h1,
        TPM_MODE_FORCE_LOW  = 2'h2,
        TPM_MODE_FORCE_HIGH = 2'h3
    } tpm_mode_type;

endpackage

// ---- design/tpm_channel.sv ----
// One output channel: match latch, mode mapping, output flop.
// Assumes count, wrap and run come from the same clock domain.
`timescale 1ns/100ps

module tpm_channel
    import tpm_pkg::*;
#(
    parameter int CNT_W = tpm_pkg::TPM_CNT_WIDTH
)
(
    input  wire logic                clk_in,
    input  wire logic                rstn_in,
    input  wire logic [CNT_W-1:0]    count_in,
    input  wire logic [CNT_W-1:0]    match_in,
    input  wire tpm_pkg::tpm_mode_type mode_in,
    input  wire logic                pwm_mode_in,
    input  wire logic                run_in,
    input  wire logic                wrap_in,
    input  wire logic                ext_level_in,
    output logic                     out_out
);

    import tpm_pkg::*;

    logic latch;
    logic next_latch;
    logic next_out;
    logic hit;
    logic level;

    // ==========================================================
    // Match latch
    // ==========================================================
    // Set on match, cleared when the timer wraps to zero
    always_comb
    begin
        hit = run_in && (count_in == match_in); // R4
        next_latch = latch;
        if (wrap_in)
        begin
            next_latch = 1'b0; // R6
        end
        else if (hit)
        begin
            next_latch = 1'b1; // R4
        end
    end

    // ==========================================================
    // Mode mapping
    // ==========================================================
    // High from the match until the wrap, i.e. count not below match and not at the wrap value
    always_comb
    begin
        level = (latch | hit) & ~wrap_in;
        next_out = ext_level_in; // R1
        if (pwm_mode_in)
        begin
            case (mode_in)
                TPM_MODE_LOW_FIRST:  next_out = level;      // R7
                TPM_MODE_HIGH_FIRST: next_out = ~level;     // R8
                TPM_MODE_FORCE_LOW:  next_out = 1'b0;       // R9
                TPM_MODE_FORCE_HIGH: next_out = 1'b1;       // R10
                default:             next_out = 1'b0;
            endcase
        end
    end

    // Output from a flop, so it never glitches at the pin
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            latch   <= 1'b0;
            out_out <= 1'b0;
        end
        else
        begin
            latch   <= next_latch;
            out_out <= next_out;
        end
    end

endmodule

// ---- design/tpm_top.sv ----
// Timer PWM output mode control: timer, registers, output channels.
// Assumes a synchronous register master on clk_in that never waits.
//
// Behaviour
// R1 - Each output is either PWM or plain match output from external control.
// R2 - No more than four outputs, the lowest selected, may run as PWM.
// R3 - One chosen match register sets the PWM cycle length.
// R4 - A match on any other match register drives its PWM output high.
// R5 - A match on the cycle-length register resets the count to zero.
// R6 - On the reset to zero, all high PWM outputs drop low.
// R7 - Mode 00: low while count is below match, else high.
// R8 - Mode 01: high while count is below match, else low.
// R9 - Mode 10 forces the output low; output 15 field is bits 31:30.
// R10 - Mode 11 forces the output high regardless of count.
// R11 - Output 4 field is bits 9:8, lower fields below, reset zero.
// R12 - Field k is bits 2k+1:2k; writes act from next clock.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps

module tpm_top
    import tpm_pkg::*;
#(
    parameter int CHANNELS = tpm_pkg::TPM_CHANNELS,
    parameter int CNT_W    = tpm_pkg::TPM_CNT_WIDTH,
    parameter int MAX_PWM  = tpm_pkg::TPM_MAX_PWM
)
(
    input  wire logic                          clk_in,
    input  wire logic                          rstn_in,
    input  wire logic [tpm_pkg::TPM_ADDR_W-1:0] addr_in,
    input  wire logic [tpm_pkg::TPM_DATA_W-1:0] wdata_in,
    input  wire logic                          write_in,
    input  wire logic                          read_in,
    output logic      [tpm_pkg::TPM_DATA_W-1:0] rdata_out,
    output logic      [CHANNELS-1:0]           pwm_out,
    output logic                               cycle_wrap_out
);

    import tpm_pkg::*;

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    // The mode register holds two bits per channel in 32 bits
    if (CHANNELS < 1 || CHANNELS * TPM_FIELD_W > TPM_DATA_W)
    begin : g_bad_channels
        $error("tpm_top: CHANNELS out of range");
    end
    if (CHANNELS > (1 << TPM_SEL_W))
    begin : g_bad_select
        $error("tpm_top: CHANNELS exceeds cycle select range");
    end
    if (CNT_W < 1 || CNT_W > TPM_CNT_WIDTH)
    begin : g_bad_width
        $error("tpm_top: CNT_W out of range");
    end
    if (MAX_PWM < 1 || MAX_PWM > CHANNELS)
    begin : g_bad_max
        $error("tpm_top: MAX_PWM out of range");
    end

    // ==========================================================
    // State
    // ==========================================================
    logic [TPM_DATA_W-1:0] pwm_output_mode_control;
    logic [TPM_DATA_W-1:0] next_mode_ctrl;
    logic                  run;
    logic                  next_run;
    logic [CNT_W-1:0]      timer_count;
    logic [CNT_W-1:0]      next_count;
    logic [TPM_SEL_W-1:0]  cycle_sel;
    logic [TPM_SEL_W-1:0]  next_cycle_sel;
    logic [CHANNELS-1:0]   pwm_sel;
    logic [CHANNELS-1:0]   next_pwm_sel;
    logic [CHANNELS-1:0]   external_match_control;
    logic [CHANNELS-1:0]   next_ext;
    logic [CNT_W-1:0]      match_value [CHANNELS];
    logic [CNT_W-1:0]      next_match  [CHANNELS];
    logic [TPM_DATA_W-1:0] next_rdata;
    logic                  cnt_clear;
    logic                  wrap;
    logic [CHANNELS-1:0]   cycle_onehot;
    logic [CHANNELS-1:0]   pwm_active;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Keep only the lowest MAX_PWM set bits of a select mask
    function automatic logic [CHANNELS-1:0] limit_pwm(
        input logic [CHANNELS-1:0] req
    );
        logic [CHANNELS-1:0] kept;
        int                  taken;
        kept  = '0;
        taken = 0;
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (req[i] && taken < MAX_PWM)
            begin
                kept[i] = 1'b1; // R2
                taken   = taken + 1;
            end
        end
        return kept;
    endfunction

    // Index of a match register word, or CHANNELS when none
    function automatic int match_index(
        input logic [TPM_ADDR_W-1:0] a
    );
        int idx;
        idx = CHANNELS;
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (a == TPM_ADDR_W'(TPM_OFS_MATCH_BASE
                                 + TPM_OFS_WORD_STEP * i))
            begin
                idx = i;
            end
        end
        return idx;
    endfunction

    // ==========================================================
    // Register writes
    // ==========================================================
    // Unmapped writes are dropped without any side effect
    always_comb
    begin
        int widx;
        widx           = match_index(addr_in);
        next_mode_ctrl = pwm_output_mode_control;
        next_run       = run;
        next_cycle_sel = cycle_sel;
        next_pwm_sel   = pwm_sel;
        next_ext       = external_match_control;
        cnt_clear      = 1'b0;
        for (int i = 0; i < CHANNELS; i++)
        begin
            next_match[i] = match_value[i];
        end
        if (write_in)
        begin
            case (addr_in)
                TPM_OFS_MODE_CTRL:
                begin
                    next_mode_ctrl = wdata_in; // R12
                end
                TPM_OFS_TIMER_CTRL:
                begin
                    next_run  = wdata_in[TPM_BIT_RUN];
                    cnt_clear = wdata_in[TPM_BIT_CNT_CLEAR];
                end
                TPM_OFS_CYCLE_SEL:
                begin
                    next_cycle_sel = wdata_in[TPM_SEL_W-1:0]; // R3
                end
                TPM_OFS_PWM_SEL:
                begin
                    next_pwm_sel = limit_pwm(wdata_in[CHANNELS-1:0]);
                end
                TPM_OFS_EXT_MATCH:
                begin
                    next_ext = wdata_in[CHANNELS-1:0]; // R1
                end
                default:
                begin
                    if (widx < CHANNELS)
                    begin
                        next_match[widx] = wdata_in[CNT_W-1:0];
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Timer
    // ==========================================================
    // Counting runs only while enabled; clear wins over counting
    always_comb
    begin
        wrap       = run && (timer_count == match_value[cycle_sel]); // R5
        next_count = timer_count;
        if (cnt_clear)
        begin
            next_count = '0;
        end
        else if (wrap)
        begin
            next_count = '0; // R5
        end
        else if (run)
        begin
            next_count = timer_count + CNT_W'(TPM_COUNT_STEP);
        end
    end

    // Cycle-length channel never acts as a PWM output itself
    always_comb
    begin
        cycle_onehot = '0;
        for (int i = 0; i < CHANNELS; i++)
        begin
            cycle_onehot[i] = (cycle_sel == TPM_SEL_W'(i)); // R3
        end
        pwm_active = pwm_sel & ~cycle_onehot; // R4
    end

    // ==========================================================
    // Read path
    // ==========================================================
    // Data stand only in the cycle after the strobe, else zero
    always_comb
    begin
        int ridx;
        ridx       = match_index(addr_in);
        next_rdata = TPM_READ_ZERO;
        if (read_in)
        begin
            case (addr_in)
                TPM_OFS_MODE_CTRL:
                    next_rdata = pwm_output_mode_control;
                TPM_OFS_TIMER_CTRL:
                    next_rdata[TPM_BIT_RUN] = run;
                TPM_OFS_TIMER_CNT:
                    next_rdata[CNT_W-1:0] = timer_count;
                TPM_OFS_CYCLE_SEL:
                    next_rdata[TPM_SEL_W-1:0] = cycle_sel;
                TPM_OFS_PWM_SEL:
                    next_rdata[CHANNELS-1:0] = pwm_sel;
                TPM_OFS_EXT_MATCH:
                    next_rdata[CHANNELS-1:0] = external_match_control;
                default:
                begin
                    if (ridx < CHANNELS)
                    begin
                        next_rdata[CNT_W-1:0] = match_value[ridx];
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            pwm_output_mode_control <= TPM_RST_MODE_CTRL; // R11
            run                     <= 1'b0;
            timer_count             <= CNT_W'(TPM_RST_COUNT);
            cycle_sel               <= TPM_RST_CYCLE_SEL;
            pwm_sel                 <= CHANNELS'(TPM_RST_MASK);
            external_match_control  <= CHANNELS'(TPM_RST_MASK);
            rdata_out               <= TPM_READ_ZERO;
            cycle_wrap_out          <= 1'b0;
            for (int i = 0; i < CHANNELS; i++)
            begin
                match_value[i] <= CNT_W'(TPM_RST_MATCH);
            end
        end
        else
        begin
            pwm_output_mode_control <= next_mode_ctrl;
            run                     <= next_run;
            timer_count             <= next_count;
            cycle_sel               <= next_cycle_sel;
            pwm_sel                 <= next_pwm_sel;
            external_match_control  <= next_ext;
            rdata_out               <= next_rdata;
            cycle_wrap_out          <= wrap;
            for (int i = 0; i < CHANNELS; i++)
            begin
                match_value[i] <= next_match[i];
            end
        end
    end

    // ==========================================================
    // Output channels
    // ==========================================================
    // Field k sits at bits 2k+1:2k; field 4 lands at 9:8
    for (genvar k = 0; k < CHANNELS; k++)
    begin : g_chan
        tpm_channel #(
            .CNT_W        (CNT_W)
        ) u_chan (
            .clk_in       (clk_in),
            .rstn_in      (rstn_in),
            .count_in     (timer_count),
            .match_in     (match_value[k]),
            .mode_in      (tpm_mode_type'(
                pwm_output_mode_control[TPM_FIELD_W*k +: TPM_FIELD_W])),
            .pwm_mode_in  (pwm_active[k]),  // R1
            .run_in       (run),
            .wrap_in      (wrap),           // R6
            .ext_level_in (external_match_control[k]),
            .out_out      (pwm_out[k])      // R9
        );
    end

endmodule

// ---- sim/tpm_props.sv ----
// Port-level checker for the timer PWM output mode block.
// Assumes binding to tpm_top; registers are shadowed from bus writes.
`timescale 1ns/100ps

module tpm_props
    import tpm_pkg::*;
#(
    parameter int CHANNELS = tpm_pkg::TPM_CHANNELS,
    parameter int CNT_W    = tpm_pkg::TPM_CNT_WIDTH,
    parameter int MAX_PWM  = tpm_pkg::TPM_MAX_PWM
)
(
    input wire logic                           clk_in,
    input wire logic                           rstn_in,
    input wire logic [tpm_pkg::TPM_ADDR_W-1:0] addr_in,
    input wire logic [tpm_pkg::TPM_DATA_W-1:0] wdata_in,
    input wire logic                           write_in,
    input wire logic                           read_in,
    input wire logic [tpm_pkg::TPM_DATA_W-1:0] rdata_out,
    input wire logic [CHANNELS-1:0]            pwm_out,
    input wire logic                           cycle_wrap_out
);

    // ==========================================================
    // Register shadows
    // ==========================================================
    logic [31:0] mode;
    logic [31:0] next_mode;
    logic [15:0] sel;
    logic [15:0] next_sel;
    logic [3:0]  cyc;
    logic [3:0]  next_cyc;
    logic        ext_hi;
    logic        next_ext_hi;
    logic [1:0]  quiet;
    logic [1:0]  next_quiet;
    logic [15:0] mval      [16];
    logic [15:0] next_mval [16];
    logic        settled;

    // Quiet counts edges since a write, so output lag never misleads
    always_comb
    begin
        next_mode = mode;
        next_sel = sel;
        next_cyc = cyc;
        next_ext_hi = ext_hi;
        next_mval = mval;
        next_quiet = (quiet == 2'h3) ? quiet : quiet + 2'h1;
        if (write_in)
        begin
            next_quiet = 2'h0;
            if (addr_in == TPM_OFS_MODE_CTRL)
                next_mode = wdata_in;
            if (addr_in == TPM_OFS_PWM_SEL)
                next_sel = wdata_in[15:0];
            if (addr_in == TPM_OFS_CYCLE_SEL)
                next_cyc = wdata_in[3:0];
            if (addr_in == TPM_OFS_EXT_MATCH)
                next_ext_hi = wdata_in[15];
            if (addr_in[7:6] == 2'h1 && addr_in[1:0] == 2'h0)
                next_mval[addr_in[5:2]] = wdata_in[15:0];
        end
    end

    // Shadow registers
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            mode <= 32'h0000_0000;
            sel <= 16'h0000;
            cyc <= 4'h0;
            ext_hi <= 1'b0;
            quiet <= 2'h0;
            mval <= '{default: 16'h0000};
        end
        else
        begin
            mode <= next_mode;
            sel <= next_sel;
            cyc <= next_cyc;
            ext_hi <= next_ext_hi;
            quiet <= next_quiet;
            mval <= next_mval;
        end
    end

    // Channel 0 is PWM and not the cycle channel, config stable
    assign settled = (quiet == 2'h3) && sel[0] && (cyc != 4'h0);

    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_wr_mode;
        write_in && addr_in == TPM_OFS_MODE_CTRL;
    endsequence
    sequence s_rd_mode;
        read_in && addr_in == TPM_OFS_MODE_CTRL;
    endsequence
    sequence s_wr_sel;
        write_in && addr_in == TPM_OFS_PWM_SEL;
    endsequence
    sequence s_rd_sel;
        read_in && addr_in == TPM_OFS_PWM_SEL;
    endsequence

    property p_mode_rdbk;
        s_wr_mode ##1 s_rd_mode |=> rdata_out == $past(wdata_in, 2);
    endproperty
    property p_sel_limit;
        s_wr_sel ##1 s_rd_sel |=>
            rdata_out[31:4] == 28'h0 && $countones(rdata_out) <= MAX_PWM;
    endproperty
    property p_force_low;
        settled && mode[1:0] == 2'h2 |-> !pwm_out[0];
    endproperty
    property p_force_high;
        settled && mode[1:0] == 2'h3 |-> pwm_out[0];
    endproperty
    property p_wrap_low;
        settled && mode[1:0] == 2'h0 && cycle_wrap_out |-> !pwm_out[0];
    endproperty
    // Channel 1 carries the inverted mode in the bench, so watch it there
    property p_wrap_inv;
        quiet == 2'h3 && sel[1] && cyc != 4'h1 && mode[3:2] == 2'h1
            && cycle_wrap_out |-> pwm_out[1];
    endproperty
    property p_hold_high;
        settled && mode[1:0] == 2'h0 && !cycle_wrap_out && $past(pwm_out[0])
            |-> pwm_out[0];
    endproperty
    property p_ext_level;
        quiet == 2'h3 && (!sel[15] || $countones(sel[14:0]) >= MAX_PWM)
            |-> pwm_out[15] == ext_hi;
    endproperty
    property p_wrap_gap;
        quiet == 2'h3 && cycle_wrap_out && mval[cyc] != 16'h0000
            |=> !cycle_wrap_out;
    endproperty

    a_mode_rdbk: assert property (p_mode_rdbk)
        else $error("mode register read back differs from write");
    a_sel_limit: assert property (p_sel_limit)
        else $error("more than four PWM outputs selected");
    a_force_low: assert property (p_force_low)
        else $error("forced low output is high");
    a_force_high: assert property (p_force_high)
        else $error("forced high output is low");
    a_wrap_low: assert property (p_wrap_low)
        else $error("output not cleared at counter wrap");
    a_wrap_inv: assert property (p_wrap_inv)
        else $error("inverted output not high at counter wrap");
    a_hold_high: assert property (p_hold_high)
        else $error("output dropped before counter wrap");
    a_ext_level: assert property (p_ext_level)
        else $error("non PWM output differs from external level");
    a_wrap_gap: assert property (p_wrap_gap)
        else $error("wrap pulse longer than one cycle");

endmodule

// ---- sim/test_timer_pwm_output_mode_control.sv ----
// Self-checking bench for the timer PWM output mode block.
// Assumes tpm_top and tpm_props compiled before this file.
`timescale 1ns/100ps

module test_timer_pwm_output_mode_control;
    import tpm_pkg::*;

    logic                  clk_in;
    logic                  rstn_in;
    logic [TPM_ADDR_W-1:0] addr_in;
    logic [TPM_DATA_W-1:0] wdata_in;
    logic                  write_in;
    logic                  read_in;
    logic [TPM_DATA_W-1:0] rdata_out;
    logic [15:0]           pwm_out;
    logic                  cycle_wrap_out;
    logic [31:0]           rd_val;
    logic [3:0]            exp_pwm;
    int                    miscompares;
    int                    cmp_count;
    int                    cnt_val;
    int                    match_tab [4] = '{2, 3, 0, 5};
    logic [31:0]           pat [3] = '{32'hc000_0000, 32'h0000_0300,
                                       32'h9c3a_5e71};

    tpm_top dut (
        .clk_in         (clk_in),
        .rstn_in        (rstn_in),
        .addr_in        (addr_in),
        .wdata_in       (wdata_in),
        .write_in       (write_in),
        .read_in        (read_in),
        .rdata_out      (rdata_out),
        .pwm_out        (pwm_out),
        .cycle_wrap_out (cycle_wrap_out)
    );

    // ==========================================================
    // Clock and watchdog
    // ==========================================================
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Whole run needs under a hundred cycles; 5000 cycles is ample
    initial
    begin
        #50000;
        miscompares++;
        results();
    end

    // ==========================================================
    // Tasks: all start and end 1 ns after a rising edge
    // ==========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_in <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        @(posedge clk_in);
        write_in <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge clk_in);
        read_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] d;
        rd(a, d);
        check(d, want);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        rstn_in = 1'b0;
        addr_in = '0;
        wdata_in = '0;
        write_in = 1'b0;
        read_in = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        #1;
        check(32'(pwm_out), 32'h0);
        chk_rd(TPM_OFS_MODE_CTRL, TPM_RST_MODE_CTRL);
        // Mode register storage seen through back-to-back write and read
        foreach (pat[i])
        begin
            wr(TPM_OFS_MODE_CTRL, pat[i]);
            chk_rd(TPM_OFS_MODE_CTRL, pat[i]);
        end
        wr(8'hfc, 32'hffff_ffff);
        chk_rd(8'hfc, 32'h0);
        // Channel 4 sets the period: count runs 0..5
        for (int k = 0; k < 4; k++)
            wr(TPM_OFS_MATCH_BASE + 8'(4 * k), 32'(match_tab[k]));
        wr(TPM_OFS_MATCH_BASE + 8'h10, 32'h5);
        wr(TPM_OFS_CYCLE_SEL, 32'h4);
        wr(TPM_OFS_PWM_SEL, 32'hffff);
        chk_rd(TPM_OFS_PWM_SEL, 32'h0000_000f);
        wr(TPM_OFS_EXT_MATCH, 32'ha5f0);
        wr(TPM_OFS_MODE_CTRL, 32'h4);
        wr(TPM_OFS_TIMER_CTRL, 32'h1);
        idle(3);
        check(32'(pwm_out[15:4]), 32'ha5f);
        for (int i = 0; i < 20 && cycle_wrap_out !== 1'b1; i++)
            idle(1);
        // Reading the count also steps one cycle per pass
        cnt_val = 0;
        repeat (12)
        begin
            for (int k = 0; k < 4; k++)
                exp_pwm[k] = (cnt_val > match_tab[k]) ^ (k == 1);
            check(32'(pwm_out[3:0]), 32'(exp_pwm));
            check(32'(cycle_wrap_out), 32'(cnt_val == 0));
            rd(TPM_OFS_TIMER_CNT, rd_val);
            check(rd_val, 32'(cnt_val));
            cnt_val = (cnt_val + 1) % 6;
        end
        // Forced levels on each PWM channel while the timer runs
        for (int k = 0; k < 4; k++)
            for (int md = 2; md < 4; md++)
            begin
                wr(TPM_OFS_MODE_CTRL, 32'(md) << (2 * k));
                idle(3);
                check(32'(pwm_out[k]), 32'(md % 2));
            end
        results();
    end

endmodule

bind tpm_top tpm_props #(
    .CHANNELS (CHANNELS),
    .CNT_W    (CNT_W),
    .MAX_PWM  (MAX_PWM)
) u_props (
    .clk_in         (clk_in),
    .rstn_in        (rstn_in),
    .addr_in        (addr_in),
    .wdata_in       (wdata_in),
    .write_in       (write_in),
    .read_in        (read_in),
    .rdata_out      (rdata_out),
    .pwm_out        (pwm_out),
    .cycle_wrap_out (cycle_wrap_out)
);
